// *** verilog/frcsp_map.vh ***
// Constants for the shared-pin and strap logic of the frame-rate converter.
// Assumes inclusion by bare name from design files under verilog/.
`ifndef FRCSP_MAP_VH
`define FRCSP_MAP_VH

// Number of pins and straps that pass through the input synchroniser.
`define FRCSP_SYNC_W 8
// Positions of each asynchronous input in the synchroniser vector.
`define FRCSP_SI_CLAMP 0
`define FRCSP_SI_FLIP 1
`define FRCSP_SI_HSYNC 2
`define FRCSP_SI_VSYNC 3
`define FRCSP_SI_SCLK 4
`define FRCSP_SI_SEL_N 5
`define FRCSP_SI_SIN 6
`define FRCSP_SI_SDATA 7
// Last bit index of a serial byte.
`define FRCSP_BIT_LAST 3'h7
// Reset values.
`define FRCSP_OE_N_RST 1'h1
`define FRCSP_BIT_RST 3'h0
`define FRCSP_BYTE_RST 8'h00
// Strap level that selects most significant bit first.
`define FRCSP_MSB_FIRST 1'h1
// Strap level that selects falling-edge input sampling.
`define FRCSP_POL_FALL 1'h0

`endif

// *** verilog/frcsp_sync.v ***
// Two-flop synchroniser for a vector of independent asynchronous levels.
// Assumes each bit is a slow level or a clock much slower than core_clk.
`timescale 1ns/1ps
`default_nettype none

module frcsp_sync #(
    parameter WIDTH = 1
) (
    input wire core_clk,
    input wire [WIDTH-1:0] async_in,
    output reg [WIDTH-1:0] sync_out
);

    // First stage; read only by the second stage below.
    reg [WIDTH-1:0] meta_r;

    // No reset here, so straps keep being sampled while reset is held.
    always @(posedge core_clk) begin
        meta_r <= async_in;
        sync_out <= meta_r;
    end

endmodule

`default_nettype wire

// *** verilog/frcsp_top.v ***
// Shared pins, reset straps, serial shifter and frame drop/repeat logic.
// Assumes pins are asynchronous to core_clk and control ports are not.
//
// Contract
// - Drop or repeat whole frames for output rate.
// - Serve scaler pixel requests to sustain display timing.
// - Host port works in three- and four-wire forms.
// - Data-active high inside programmed input window.
// - Interrupt-enable bit picks data-active or interrupt.
// - Clamp pulse with programmable delay and width.
// - Clamp pin is bit-order strap during reset.
// - Strap one shifts most significant bit first.
// - Interlace mode toggles phase flip every frame.
// - Phase-flip pin is polarity strap during reset.
// - Polarity strap zero samples input on falling edge.
// - Polarity strap sets both sample and shift edges.
// - Falling-edge sampling shifts output on rising edge.
`timescale 1ns/1ps
`default_nettype none
`include "frcsp_map.vh"

module frcsp_top #(
    parameter CNT_W = 12
) (
    input wire core_clk,
    input wire rst_n,
    input wire clamp_pin_in,
    output reg clamp_pin_out,
    output reg clamp_pin_oe_n,
    input wire flip_pin_in,
    output reg adc_sample_phase_flip,
    output reg flip_pin_oe_n,
    input wire graphics_hsync_in,
    input wire graphics_vsync_in,
    input wire in_pixel_strobe,
    input wire [CNT_W-1:0] win_h_start,
    input wire [CNT_W-1:0] win_h_end,
    input wire [CNT_W-1:0] win_v_start,
    input wire [CNT_W-1:0] win_v_end,
    input wire [CNT_W-1:0] clamp_delay,
    input wire [CNT_W-1:0] clamp_width,
    input wire hinterlace_mode,
    input wire irq_out_en,
    input wire irq_request,
    output reg input_window_valid,
    input wire out_frame_start,
    input wire scaler_pixel_req,
    output reg store_read_strobe,
    output reg write_buf_sel,
    output reg read_buf_sel,
    output reg frame_dropped,
    output reg frame_repeated,
    input wire three_wire_mode,
    input wire serial_clk_in,
    input wire serial_select_n,
    input wire serial_in,
    input wire serial_data_in,
    output reg serial_out,
    output reg serial_out_oe_n,
    output reg serial_data_oe_n,
    input wire [7:0] tx_byte,
    input wire tx_load,
    input wire tx_drive,
    output reg [7:0] rx_byte,
    output reg rx_valid,
    output reg serial_bit_order_strap,
    output reg shift_clock_edge_strap
);

    // Synchronised copies of every pin input.
    wire [`FRCSP_SYNC_W-1:0] pins_s;
    // Previous synchronised values, for edge detection.
    reg hs_d_r;
    reg vs_d_r;
    reg sclk_d_r;
    // Window counters: pixels in a line and lines in a frame.
    reg [CNT_W-1:0] hcnt_r;
    reg [CNT_W-1:0] vcnt_r;
    // Clamp timing counter and phase.
    reg [CNT_W-1:0] clamp_cnt_r;
    reg clamp_wait_r;
    // Set when a complete input frame waits for the output side.
    reg frame_ready_r;
    // Serial shifter state.
    reg [7:0] rx_sh_r;
    reg [7:0] tx_sh_r;
    reg [2:0] bit_r;

    frcsp_sync #(
        .WIDTH(`FRCSP_SYNC_W)
    ) u_sync (
        .core_clk(core_clk),
        .async_in({serial_data_in, serial_in, serial_select_n,
                   serial_clk_in, graphics_vsync_in, graphics_hsync_in,
                   flip_pin_in, clamp_pin_in}),
        .sync_out(pins_s)
    );

    // Edges found on the synchronised pins.
    wire hs_rise = pins_s[`FRCSP_SI_HSYNC] & ~hs_d_r;
    wire vs_rise = pins_s[`FRCSP_SI_VSYNC] & ~vs_d_r;
    wire sclk_rise = pins_s[`FRCSP_SI_SCLK] & ~sclk_d_r;
    wire sclk_fall = ~pins_s[`FRCSP_SI_SCLK] & sclk_d_r;
    // Active edges chosen by the latched polarity strap.
    wire pol_fall = (shift_clock_edge_strap == `FRCSP_POL_FALL);
    wire sample_edge = pol_fall ? sclk_fall : sclk_rise;
    wire shift_edge = pol_fall ? sclk_rise : sclk_fall;
    wire selected = ~pins_s[`FRCSP_SI_SEL_N];
    // Three-wire form shares one data pin for both directions.
    wire din = three_wire_mode ? pins_s[`FRCSP_SI_SDATA]
                               : pins_s[`FRCSP_SI_SIN];
    wire msb_first = (serial_bit_order_strap == `FRCSP_MSB_FIRST);
    // Next receive word with the new bit placed by bit order.
    wire [7:0] rx_next = msb_first ? {rx_sh_r[6:0], din}
                                   : {din, rx_sh_r[7:1]};

    // Straps follow the pins while reset is held and freeze on release.
    // Sampling goes through the synchroniser, so the captured level is the
    // pin as it stood two cycles before the release edge.
    always @(posedge core_clk) begin
        if (!rst_n) begin
            serial_bit_order_strap <= pins_s[`FRCSP_SI_CLAMP];
            shift_clock_edge_strap <= pins_s[`FRCSP_SI_FLIP];
        end
    end

    // Edge history registers. During reset they follow the pins as well, so
    // a shift clock that idles high gives no false edge after release.
    always @(posedge core_clk) begin
        if (!rst_n) begin
            hs_d_r <= pins_s[`FRCSP_SI_HSYNC];
            vs_d_r <= pins_s[`FRCSP_SI_VSYNC];
            sclk_d_r <= pins_s[`FRCSP_SI_SCLK];
        end else begin
            hs_d_r <= pins_s[`FRCSP_SI_HSYNC];
            vs_d_r <= pins_s[`FRCSP_SI_VSYNC];
            sclk_d_r <= pins_s[`FRCSP_SI_SCLK];
        end
    end

    // Window counters and the shared data-active / interrupt pin.
    always @(posedge core_clk) begin
        if (!rst_n) begin
            hcnt_r <= {CNT_W{1'b0}};
            vcnt_r <= {CNT_W{1'b0}};
            input_window_valid <= 1'h0;
        end else begin
            if (hs_rise) begin
                hcnt_r <= {CNT_W{1'b0}};
            end else if (in_pixel_strobe) begin
                hcnt_r <= hcnt_r + {{(CNT_W-1){1'b0}}, 1'b1};
            end
            if (vs_rise) begin
                vcnt_r <= {CNT_W{1'b0}};
            end else if (hs_rise) begin
                vcnt_r <= vcnt_r + {{(CNT_W-1){1'b0}}, 1'b1};
            end
            // The pin is steered by the interrupt enable bit.
            if (irq_out_en) begin
                input_window_valid <= irq_request;
            end else begin
                input_window_valid <= (hcnt_r >= win_h_start) &&
                                      (hcnt_r < win_h_end) &&
                                      (vcnt_r >= win_v_start) &&
                                      (vcnt_r < win_v_end);
            end
        end
    end

    // Clamp pulse: wait clamp_delay cycles after hsync, then high for
    // clamp_width + 1 cycles, or not at all when clamp_width is zero. A new
    // hsync restarts the sequence, so a delay longer than a line never yields a pulse.
    always @(posedge core_clk) begin
        if (!rst_n) begin
            clamp_cnt_r <= {CNT_W{1'b0}};
            clamp_wait_r <= 1'h0;
            clamp_pin_out <= 1'h0;
        end else if (hs_rise) begin
            clamp_cnt_r <= clamp_delay;
            clamp_wait_r <= 1'h1;
            clamp_pin_out <= 1'h0;
        end else if (clamp_cnt_r != {CNT_W{1'b0}}) begin
            clamp_cnt_r <= clamp_cnt_r - {{(CNT_W-1){1'b0}}, 1'b1};
        end else if (clamp_wait_r) begin
            // Delay over: open the pulse unless its width is zero.
            clamp_wait_r <= 1'h0;
            clamp_cnt_r <= clamp_width;
            clamp_pin_out <= (clamp_width != {CNT_W{1'b0}});
        end else begin
            clamp_pin_out <= 1'h0;
        end
    end

    // Pin direction: straps are inputs during reset, outputs afterwards.
    always @(posedge core_clk) begin
        if (!rst_n) begin
            clamp_pin_oe_n <= `FRCSP_OE_N_RST;
            flip_pin_oe_n <= `FRCSP_OE_N_RST;
            adc_sample_phase_flip <= 1'h0;
        end else begin
            clamp_pin_oe_n <= 1'h0;
            flip_pin_oe_n <= 1'h0;
            if (hinterlace_mode && vs_rise) begin
                adc_sample_phase_flip <= ~adc_sample_phase_flip;
            end
        end
    end

    // Frame scheduling. An input frame ends at graphics vsync; the output
    // frame start picks the newest finished frame, or repeats the old one.
    always @(posedge core_clk) begin
        if (!rst_n) begin
            frame_ready_r <= 1'h0;
            write_buf_sel <= 1'h0;
            read_buf_sel <= 1'h1;
            frame_dropped <= 1'h0;
            frame_repeated <= 1'h0;
            store_read_strobe <= 1'h0;
        end else begin
            // Each scaler request is answered next cycle.
            store_read_strobe <= scaler_pixel_req;
            frame_dropped <= 1'h0;
            frame_repeated <= 1'h0;
            if (out_frame_start && (frame_ready_r || vs_rise)) begin
                // Display the newest whole frame; writing moves on.
                read_buf_sel <= write_buf_sel;
                write_buf_sel <= ~write_buf_sel;
                frame_ready_r <= 1'h0;
                frame_dropped <= frame_ready_r & vs_rise;
            end else if (out_frame_start) begin
                frame_repeated <= 1'h1;
            end else if (vs_rise) begin
                // An unread finished frame is overwritten: dropped.
                frame_dropped <= frame_ready_r;
                frame_ready_r <= 1'h1;
            end
        end
    end

    // Serial shifter. Receive on the sampling edge, transmit on the other.
    always @(posedge core_clk) begin
        if (!rst_n) begin
            rx_sh_r <= `FRCSP_BYTE_RST;
            tx_sh_r <= `FRCSP_BYTE_RST;
            bit_r <= `FRCSP_BIT_RST;
            rx_byte <= `FRCSP_BYTE_RST;
            rx_valid <= 1'h0;
            serial_out <= 1'h0;
            serial_out_oe_n <= `FRCSP_OE_N_RST;
            serial_data_oe_n <= `FRCSP_OE_N_RST;
        end else begin
            rx_valid <= 1'h0;
            // Four-wire drives its own output pin; three-wire the data pin.
            serial_out_oe_n <= ~(selected & tx_drive & ~three_wire_mode);
            serial_data_oe_n <= ~(selected & tx_drive & three_wire_mode);
            if (!selected) begin
                bit_r <= `FRCSP_BIT_RST;
            end else if (sample_edge) begin
                rx_sh_r <= rx_next;
                bit_r <= bit_r + 3'h1;
                if (bit_r == `FRCSP_BIT_LAST) begin
                    rx_byte <= rx_next;
                    rx_valid <= 1'h1;
                end
            end
            if (tx_load) begin
                tx_sh_r <= tx_byte;
                serial_out <= msb_first ? tx_byte[7] : tx_byte[0];
            end else if (selected && shift_edge) begin
                tx_sh_r <= msb_first ? {tx_sh_r[6:0], 1'b0}
                                     : {1'b0, tx_sh_r[7:1]};
                serial_out <= msb_first ? tx_sh_r[6] : tx_sh_r[1];
            end
        end
    end

endmodule

`default_nettype wire

// *** testbench/frcsp_host_model.sv ***
// Behavioural host microcontroller on the serial port of the block.
// Assumes the bench sets pol and msb to match the latched straps, and tw to the wire mode.
`timescale 1ns/1ps
`default_nettype none
module frcsp_host_model (
    input wire logic pol,
    input wire logic msb,
    input wire logic tw,
    input wire logic sout,
    input wire logic sout_oe_n,
    input wire logic sdata_oe_n,
    output logic sclk,
    output logic sel_n,
    output logic sin,
    output logic sdata
);
    logic bit_r = 1'b0; // Bit the host presents now.
    // An undriven four-wire output reads back inverted, so a missing enable
    // shows up as a wrong byte.
    wire sout_pin = sout_oe_n ? ~sout : sout;
    initial begin
        sclk = 1'b1;
        sel_n = 1'b1;
    end
    // The pin the block must ignore carries the inverse bit.
    assign sin = tw ? ~bit_r : bit_r;
    assign sdata = sdata_oe_n ? (tw ? bit_r : ~bit_r) : sout;
    // One frame; the host reads the block just before each shift edge.
    task automatic xfer(input logic [7:0] d, output logic [7:0] q);
        #1; // Keep pin changes off the core clock's sampling edge.
        sclk = ~pol; // Idle level makes the first edge a sample edge.
        #16 sel_n = 1'b0;
        for (int i = 0; i < 8; i++) begin
            bit_r = msb ? d[7 - i] : d[i];
            #16 sclk = pol;
            #16 q[msb ? 7 - i : i] = tw ? sdata : sout_pin;
            sclk = ~pol;
        end
        #16 sel_n = 1'b1;
        bit_r = ~bit_r; // A released line never keeps its last bit.
    endtask
endmodule
`default_nettype wire

// *** testbench/frcsp_top_monitor.sv ***
// Port-level assertions for the shared-pin and strap block.
// Assumes one core_clk domain and a synchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none
module frcsp_top_monitor #(
    parameter CNT_W = 12
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic clamp_pin_out,
    input wire logic clamp_pin_oe_n,
    input wire logic flip_pin_oe_n,
    input wire logic adc_sample_phase_flip,
    input wire logic hinterlace_mode,
    input wire logic irq_out_en,
    input wire logic irq_request,
    input wire logic input_window_valid,
    input wire logic scaler_pixel_req,
    input wire logic store_read_strobe,
    input wire logic read_buf_sel,
    input wire logic write_buf_sel,
    input wire logic frame_repeated,
    input wire logic [CNT_W-1:0] clamp_width
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    logic [CNT_W:0] hi_r; // Clamp cycles already seen in this pulse.
    // A counter keeps the width check free of long repetitions.
    always @(posedge core_clk) begin
        if (!rst_n || !clamp_pin_out) begin
            hi_r <= '0;
        end else begin
            hi_r <= hi_r + 1'h1;
        end
    end
    sequence clamp_rise;
        !clamp_pin_out ##1 clamp_pin_out;
    endsequence
    sequence no_ilace;
        !hinterlace_mode [*2];
    endsequence
    chk_oe_drive:
        assert property ($past(rst_n) && $past(rst_n, 2) |->
            !clamp_pin_oe_n && !flip_pin_oe_n) else $error("pin not driven");
    chk_irq_pass:
        assert property (irq_out_en |=> input_window_valid ==
            $past(irq_request)) else $error("shared pin not irq");
    chk_store_follow:
        assert property (1'b1 |=> store_read_strobe == $past(scaler_pixel_req))
        else $error("scaler read lost");
    chk_buf_apart:
        assert property (read_buf_sel != write_buf_sel)
        else $error("read and write buffer equal");
    chk_repeat_hold:
        assert property (frame_repeated |-> $stable(read_buf_sel))
        else $error("repeat moved read buffer");
    chk_flip_hold:
        assert property (no_ilace |-> $stable(adc_sample_phase_flip))
        else $error("phase flip outside interlace");
    chk_clamp_len:
        assert property (clamp_pin_out |-> hi_r <= {1'b0, clamp_width})
        else $error("clamp pulse too long");
    chk_clamp_zero:
        assert property (clamp_rise |-> clamp_width != 12'h000)
        else $error("clamp pulse with zero width");
endmodule
bind frcsp_top frcsp_top_monitor #(.CNT_W(CNT_W)) mon_u (
    .core_clk(core_clk), .rst_n(rst_n),
    .clamp_pin_out(clamp_pin_out), .clamp_pin_oe_n(clamp_pin_oe_n),
    .flip_pin_oe_n(flip_pin_oe_n),
    .adc_sample_phase_flip(adc_sample_phase_flip),
    .hinterlace_mode(hinterlace_mode), .irq_out_en(irq_out_en),
    .irq_request(irq_request), .input_window_valid(input_window_valid),
    .scaler_pixel_req(scaler_pixel_req),
    .store_read_strobe(store_read_strobe),
    .read_buf_sel(read_buf_sel), .write_buf_sel(write_buf_sel),
    .frame_repeated(frame_repeated), .clamp_width(clamp_width));
`default_nettype wire

// *** testbench/test_frc_shared_pins_and_straps.sv ***
// Self-checking bench for the shared-pin and strap block.
// Assumes frcsp_top, its checker and the host model are compiled first.
`timescale 1ns/1ps
`default_nettype none
module test_frc_shared_pins_and_straps;
    logic core_clk = 1'b0, rst_n = 1'b0, bo_s = 1'b0, pol_s = 1'b0;
    logic graphics_hsync_in = 1'b0, graphics_vsync_in = 1'b0;
    logic in_pixel_strobe = 1'b0, scaler_pixel_req = 1'b0;
    logic hinterlace_mode = 1'b0, irq_out_en = 1'b0, irq_request = 1'b0;
    logic out_frame_start = 1'b0, three_wire_mode = 1'b0;
    logic tx_load = 1'b0, tx_drive = 1'b0;
    logic [7:0] tx_byte = 8'h00, got;
    logic [11:0] clamp_width = 12'h004;
    // An empty window keeps the data-active level known.
    logic [11:0] win_h_start = 12'h000, win_h_end = 12'h000;
    logic [11:0] win_v_start = 12'h000, win_v_end = 12'h000;
    wire [11:0] clamp_delay = 12'h003;
    wire clamp_pin_out, clamp_pin_oe_n, adc_sample_phase_flip, flip_pin_oe_n;
    wire input_window_valid, store_read_strobe, write_buf_sel, read_buf_sel;
    wire frame_dropped, frame_repeated, serial_out, serial_out_oe_n;
    wire serial_data_oe_n, rx_valid, serial_bit_order_strap, serial_in;
    wire shift_clock_edge_strap, serial_clk_in, serial_select_n;
    wire serial_data_in;
    wire [7:0] rx_byte;
    // Strap pins read the bench level until the block takes them over.
    wire clamp_pin_in = clamp_pin_oe_n ? bo_s : clamp_pin_out;
    wire flip_pin_in = flip_pin_oe_n ? pol_s : adc_sample_phase_flip;
    int fail_count = 0, cmp_count = 0, rx_n = 0, rep_n = 0, drop_n = 0;
    int hi_n = 0;
    frcsp_top #(.CNT_W(12)) dut_u (
        .core_clk(core_clk), .rst_n(rst_n),
        .clamp_pin_in(clamp_pin_in), .clamp_pin_out(clamp_pin_out),
        .clamp_pin_oe_n(clamp_pin_oe_n), .flip_pin_in(flip_pin_in),
        .adc_sample_phase_flip(adc_sample_phase_flip),
        .flip_pin_oe_n(flip_pin_oe_n),
        .graphics_hsync_in(graphics_hsync_in),
        .graphics_vsync_in(graphics_vsync_in),
        .in_pixel_strobe(in_pixel_strobe),
        .win_h_start(win_h_start), .win_h_end(win_h_end),
        .win_v_start(win_v_start), .win_v_end(win_v_end),
        .clamp_delay(clamp_delay), .clamp_width(clamp_width),
        .hinterlace_mode(hinterlace_mode), .irq_out_en(irq_out_en),
        .irq_request(irq_request), .input_window_valid(input_window_valid),
        .out_frame_start(out_frame_start),
        .scaler_pixel_req(scaler_pixel_req),
        .store_read_strobe(store_read_strobe),
        .write_buf_sel(write_buf_sel), .read_buf_sel(read_buf_sel),
        .frame_dropped(frame_dropped), .frame_repeated(frame_repeated),
        .three_wire_mode(three_wire_mode), .serial_clk_in(serial_clk_in),
        .serial_select_n(serial_select_n), .serial_in(serial_in),
        .serial_data_in(serial_data_in), .serial_out(serial_out),
        .serial_out_oe_n(serial_out_oe_n),
        .serial_data_oe_n(serial_data_oe_n),
        .tx_byte(tx_byte), .tx_load(tx_load), .tx_drive(tx_drive),
        .rx_byte(rx_byte), .rx_valid(rx_valid),
        .serial_bit_order_strap(serial_bit_order_strap),
        .shift_clock_edge_strap(shift_clock_edge_strap));
    frcsp_host_model host_u (.pol(pol_s), .msb(bo_s), .tw(three_wire_mode),
        .sout(serial_out), .sout_oe_n(serial_out_oe_n),
        .sdata_oe_n(serial_data_oe_n),
        .sclk(serial_clk_in), .sel_n(serial_select_n), .sin(serial_in),
        .sdata(serial_data_in));
    always #2 core_clk = ~core_clk;
    // Free-running pixel traffic; counters log the one-cycle pulses and the clamp high cycles.
    always @(posedge core_clk) begin
        in_pixel_strobe <= ~in_pixel_strobe;
        scaler_pixel_req <= scaler_pixel_req ^ in_pixel_strobe;
        rx_n <= rx_n + (rx_valid === 1'b1);
        rep_n <= rep_n + (frame_repeated === 1'b1);
        drop_n <= drop_n + (frame_dropped === 1'b1);
        hi_n <= hi_n + (clamp_pin_out === 1'b1);
    end
    task automatic cyc(input int n);
        repeat (n) @(posedge core_clk);
    endtask
    task automatic chk(input logic [11:0] got_v, input logic [11:0] exp_v);
        cmp_count = cmp_count + 1;
        if (got_v !== exp_v) begin
            fail_count = fail_count + 1;
            $display("BAD %0t got %h exp %h", $time, got_v, exp_v);
        end
    endtask
    task automatic report_and_stop;
        if (fail_count == 0 && cmp_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    // A vertical pulse when v is set, a horizontal one otherwise.
    task automatic sync_pulse(input logic v);
        graphics_vsync_in <= v;
        graphics_hsync_in <= ~v;
        cyc(4);
        graphics_vsync_in <= 1'b0;
        graphics_hsync_in <= 1'b0;
        cyc(30);
    endtask
    task automatic frame_go;
        out_frame_start <= 1'b1;
        cyc(1);
        out_frame_start <= 1'b0;
        cyc(3);
    endtask
    // Reset with one strap pair, then receive a byte and send one.
    task automatic run_cfg(input logic [1:0] cfg);
        int n0;
        rst_n <= 1'b0;
        bo_s <= cfg[0];
        pol_s <= cfg[0] ^ cfg[1];
        three_wire_mode <= cfg[1];
        cyc(4);
        rst_n <= 1'b1;
        cyc(2);
        chk(serial_bit_order_strap, cfg[0]);
        chk(shift_clock_edge_strap, cfg[0] ^ cfg[1]);
        n0 = rx_n;
        host_u.xfer(8'h1D, got);
        cyc(16);
        chk(rx_n - n0, 1);
        chk(rx_byte, 8'h1D);
        tx_byte <= 8'hB2;
        tx_load <= 1'b1;
        tx_drive <= 1'b1;
        cyc(1);
        tx_load <= 1'b0;
        host_u.xfer(8'h4D, got);
        chk(got, 8'hB2);
        cyc(1);
        tx_drive <= 1'b0;
    endtask
    initial begin
        cyc(2);
        rst_n <= 1'b1;
        // Let the release stand before the first strap reset pulls it low.
        cyc(2);
        for (int c = 0; c < 4; c++) begin
            run_cfg(c[1:0]);
        end
        irq_out_en <= 1'b1;
        irq_request <= 1'b1;
        cyc(3);
        chk(input_window_valid, 1'b1);
        irq_out_en <= 1'b0;
        cyc(3);
        chk(input_window_valid, 1'b0);
        frame_go;
        chk(rep_n, 1);
        hinterlace_mode <= 1'b1;
        sync_pulse(1'b1);
        chk(adc_sample_phase_flip, 1'b1);
        hinterlace_mode <= 1'b0;
        frame_go;
        chk({read_buf_sel, write_buf_sel}, 2'h1);
        sync_pulse(1'b1);
        sync_pulse(1'b1);
        chk(drop_n, 1);
        chk(adc_sample_phase_flip, 1'b1);
        sync_pulse(1'b0);
        chk(hi_n, 5);
        clamp_width <= 12'h000;
        sync_pulse(1'b0);
        chk(hi_n, 5);
        // Two line syncs since the last frame sync put the line count at 2.
        win_h_end <= 12'hFFF;
        win_v_start <= 12'h002;
        win_v_end <= 12'h003;
        cyc(3);
        chk(input_window_valid, 1'b1);
        win_v_start <= 12'h003;
        cyc(3);
        chk(input_window_valid, 1'b0);
        report_and_stop;
    end
endmodule
`default_nettype wire
